// ### core/srcc_top.sv
`timescale 1ns/10ps
`include "srcc_defs.svh"
module srcc_top #(
    parameter int SAMPLE_W = 12,
    parameter int TAP_DEPTH = 32
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_sdi,
    output logic spi_sdo,
    input wire logic sync_pin,
    input wire logic [23:0] sync_capture_position,
    input wire logic sample_marker_enable,
    input wire logic decim_bypass,
    input wire logic [SAMPLE_W-1:0] sample_in,
    output logic [SAMPLE_W-1:0] sample_out,
    output logic sync_event,
    output logic sync_receiver_enable,
    output logic sync_processor_enable,
    output logic sync_window_fine_steps,
    output logic [3:0] sync_delay_tap_select,
    output logic device_clock_dc_mode,
    output logic sync_input_dc_mode,
    output logic sync_polarity_invert,
    output logic sync_as_sample_marker,
    output logic clock_feedback_gain,
    output logic analog_supply_noise_suppress,
    output logic [1:0] sampling_clock_delay
);
    // ==========================================
    // serial port
    logic wr_stb;
    logic [14:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [7:0] clock_control_primary_r;
    logic [7:0] clock_control_secondary_r;
    logic [7:0] clock_control_tertiary_r;

    srcc_spi_slave u_spi (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .spi_sclk(spi_sclk),
        .spi_cs_n(spi_cs_n),
        .spi_sdi(spi_sdi),
        .spi_sdo(spi_sdo),
        .wr_stb(wr_stb),
        .addr(addr),
        .wdata(wdata),
        .rdata(rdata)
    );

    // read mux; unmapped addresses read zero, position bytes are read-only
    function automatic logic [7:0] read_byte(input logic [14:0] a, input logic [7:0] p,
        input logic [7:0] s, input logic [7:0] t, input logic [23:0] pos);
        case (a)
            `SRCC_ADDR_PRIMARY: read_byte = p;
            `SRCC_ADDR_SECONDARY: read_byte = s;
            `SRCC_ADDR_TERTIARY: read_byte = t;
            `SRCC_ADDR_POS0: read_byte = pos[7:0]; // R15
            `SRCC_ADDR_POS1: read_byte = pos[15:8]; // R15
            `SRCC_ADDR_POS2: read_byte = pos[23:16]; // R15
            default: read_byte = 8'h00;
        endcase
    endfunction

    assign rdata = read_byte(addr, clock_control_primary_r, clock_control_secondary_r,
        clock_control_tertiary_r, sync_capture_position);

    // ==========================================
    // configuration registers; reserved bits are kept as written
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            clock_control_primary_r <= `SRCC_RST_PRIMARY; // R1 R3
        end else if (wr_stb && addr == `SRCC_ADDR_PRIMARY) begin
            clock_control_primary_r <= wdata; // R4 R5
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            clock_control_secondary_r <= `SRCC_RST_SECONDARY;
        end else if (wr_stb && addr == `SRCC_ADDR_SECONDARY) begin
            clock_control_secondary_r <= wdata; // R10 R11
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            clock_control_tertiary_r <= `SRCC_RST_TERTIARY; // R12 R14
        end else if (wr_stb && addr == `SRCC_ADDR_TERTIARY) begin
            clock_control_tertiary_r <= wdata; // R13
        end
    end

    assign sync_processor_enable = clock_control_primary_r[`SRCC_PRI_PROC_EN];
    assign sync_receiver_enable = clock_control_primary_r[`SRCC_PRI_RECV_EN];
    assign sync_window_fine_steps = clock_control_primary_r[`SRCC_PRI_FINE];
    assign sync_delay_tap_select = clock_control_primary_r[`SRCC_PRI_TAP_HI:`SRCC_PRI_TAP_LO];
    assign sync_as_sample_marker = clock_control_secondary_r[`SRCC_SEC_MARKER];
    assign device_clock_dc_mode = clock_control_secondary_r[`SRCC_SEC_DEVCLK_DC]; // R10
    assign sync_input_dc_mode = clock_control_secondary_r[`SRCC_SEC_SYNC_DC]; // R11
    assign sync_polarity_invert = clock_control_secondary_r[`SRCC_SEC_INVERT];
    assign clock_feedback_gain = clock_control_tertiary_r[`SRCC_TER_FB_GAIN]; // R12
    assign analog_supply_noise_suppress = clock_control_tertiary_r[`SRCC_TER_NOISE]; // R13
    assign sampling_clock_delay =
        clock_control_tertiary_r[`SRCC_TER_DEL_HI:`SRCC_TER_DEL_LO]; // R14

    // ==========================================
    // sync input path
    logic [1:0] sync_s;
    logic sync_rx;
    logic [TAP_DEPTH-1:0] dly_r;
    logic dly_sel_r;
    logic dly_prev_r;

    // coarse steps span two cycles, fine steps one; tap 0 of the field is the shortest delay
    function automatic logic [4:0] tap_index(input logic fine, input logic [3:0] sel);
        tap_index = fine ? {1'b0, sel} : {sel, 1'b0}; // R4 R5
    endfunction

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            sync_s <= 2'h0;
        end else begin
            sync_s <= {sync_s[0], sync_pin};
        end
    end

    // receiver off forces a quiet line; inversion happens before any processing
    assign sync_rx = sync_receiver_enable & (sync_s[1] ^ sync_polarity_invert); // R3 R9

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            dly_r <= '0;
            dly_sel_r <= 1'b0;
            dly_prev_r <= 1'b0;
        end else begin
            dly_r <= {dly_r[TAP_DEPTH-2:0], sync_rx};
            dly_sel_r <= dly_r[tap_index(sync_window_fine_steps, sync_delay_tap_select)]; // R5
            dly_prev_r <= dly_sel_r;
        end
    end

    // the processor reacts to rising edges only while enabled
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            sync_event <= 1'b0;
        end else begin
            sync_event <= sync_processor_enable & dly_sel_r & ~dly_prev_r; // R1 R2
        end
    end

    // ==========================================
    // sample marker insertion
    logic marker_on;
    assign marker_on = sync_as_sample_marker & sample_marker_enable & decim_bypass; // R7 R8

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            sample_out <= '0;
        end else if (marker_on) begin
            sample_out <= {sample_in[SAMPLE_W-1:1], sync_rx}; // R7
        end else begin
            sample_out <= sample_in; // R8
        end
    end

    // ==========================================
    // checks
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);

    sequence rx_off_seq;
        (!sync_receiver_enable)[*8];
    endsequence

    sequence sel_rise_seq;
        !dly_sel_r ##1 dly_sel_r;
    endsequence

    sequence ter_wr_seq;
        wr_stb && addr == `SRCC_ADDR_TERTIARY;
    endsequence

    sequence pos_wr_seq;
        wr_stb && addr >= `SRCC_ADDR_POS0 && addr <= `SRCC_ADDR_POS2;
    endsequence

    a_proc_gate: assert property (sync_event |-> $past(sync_processor_enable)) // R1
        else $error("sync event while processor disabled");
    a_proc_edge: assert property (sel_rise_seq ##0 sync_processor_enable |=> sync_event) // R1
        else $error("enabled processor missed a sync edge");
    a_recv_quiet: assert property (rx_off_seq |-> dly_r[6:0] == 7'h00) // R3
        else $error("sync line active with receiver off");
    a_invert_path: assert property (sync_receiver_enable |=> // R9
        dly_r[0] == ($past(sync_s[1]) ^ $past(sync_polarity_invert)))
        else $error("sync polarity path wrong");

    // tap 3 must give one cycle per step in fine mode and two in coarse mode
    a_tap_pick: assert property (sync_window_fine_steps // R4
        && sync_delay_tap_select == 4'h3 |=> dly_sel_r == $past(sync_rx, 5))
        else $error("wrong fine delay tap used");
    a_tap_coarse: assert property (!sync_window_fine_steps // R4 R5
        && sync_delay_tap_select == 4'h3 |=> dly_sel_r == $past(sync_rx, 8))
        else $error("wrong coarse delay tap used");

    a_marker_lsb: assert property (marker_on |=> sample_out[0] == $past(sync_rx)) // R7
        else $error("marker missing on sample lsb");
    a_marker_bypass: assert property (!decim_bypass |=> sample_out == $past(sample_in)) // R8
        else $error("marker inserted while decimating");

    a_prim_write: assert property (wr_stb && addr == `SRCC_ADDR_PRIMARY |=> // R1 R3 R5
        clock_control_primary_r == $past(wdata))
        else $error("primary register not updated");
    a_sec_write: assert property (wr_stb && addr == `SRCC_ADDR_SECONDARY |=> // R9 R10 R11
        clock_control_secondary_r == $past(wdata))
        else $error("secondary register not updated");
    a_tert_write: assert property (ter_wr_seq |=> // R12 R13 R14
        clock_control_tertiary_r == $past(wdata))
        else $error("tertiary register not updated");
    // position bytes are status only, a write there must leave every register alone
    a_pos_readonly: assert property (pos_wr_seq |=> $stable(clock_control_primary_r) // R15
        && $stable(clock_control_secondary_r) && $stable(clock_control_tertiary_r))
        else $error("write to position status changed a register");
    a_event_pulse: assert property (sync_event |=> !sync_event) // R1
        else $error("sync event longer than one cycle");
endmodule

// ### core/srcc_defs.svh
`ifndef SRCC_DEFS_SVH
`define SRCC_DEFS_SVH
// Functional notes
// R1: sync events reach the processor output only while primary bit 6 is set; reset is off.
// R2: software must enable the receiver (bit 5) before the processor (bit 6).
// R3: primary bit 5 powers the sync receiver when set and is off after reset.
// R4: primary bit 4 selects fine delay steps for the windowing taps and position status; the code applies it to the delay taps only.
// R5: primary bits 3:0 pick the sync capture delay tap, chosen from the capture position.
// R6: software must leave the delay tap field at zero to use automatic sync calibration.
// R7: with secondary bit 3 and the marker enable both set, the sync level replaces sample LSBs.
// R8: the sample marker from sync is inserted only when decimation is bypassed (factor one).
// R9: secondary bit 0 inverts the sync signal before it is processed.
// R10: secondary bit 2 puts the device clock input into dc-coupled low-voltage pecl mode.
// R11: secondary bit 1 puts the sync input into dc-coupled low-voltage pecl mode.
// R12: tertiary bit 4 holds the clock converter feedback gain and resets to one.
// R13: tertiary bit 2 enables analog supply noise suppression.
// R14: tertiary bits 1:0 select the sampling clock delay, one-hot, resetting to one.
// R15: a 24-bit read-only capture position status tells where the sync edge falls.

// ==========================================
// register addresses on the serial port
`define SRCC_ADDR_PRIMARY 15'h0029
`define SRCC_ADDR_SECONDARY 15'h002A
`define SRCC_ADDR_TERTIARY 15'h002B
`define SRCC_ADDR_POS0 15'h002C
`define SRCC_ADDR_POS1 15'h002D
`define SRCC_ADDR_POS2 15'h002E

// ==========================================
// reset values
`define SRCC_RST_PRIMARY 8'h00
`define SRCC_RST_SECONDARY 8'h00
`define SRCC_RST_TERTIARY 8'h11

// ==========================================
// field positions
`define SRCC_PRI_PROC_EN 6
`define SRCC_PRI_RECV_EN 5
`define SRCC_PRI_FINE 4
`define SRCC_PRI_TAP_HI 3
`define SRCC_PRI_TAP_LO 0
`define SRCC_SEC_MARKER 3
`define SRCC_SEC_DEVCLK_DC 2
`define SRCC_SEC_SYNC_DC 1
`define SRCC_SEC_INVERT 0
`define SRCC_TER_FB_GAIN 4
`define SRCC_TER_NOISE 2
`define SRCC_TER_DEL_HI 1
`define SRCC_TER_DEL_LO 0

// ==========================================
// serial frame layout: one direction bit, address, then data bytes
`define SRCC_HDR_BITS 16
`define SRCC_BYTE_BITS 8
`endif

// ### core/srcc_pkg.sv
package srcc_pkg;
    typedef enum logic [2:0] {
        SPI_IDLE = 3'b001,
        SPI_HDR = 3'b010,
        SPI_DATA = 3'b100
    } srcc_spi_state_t;
endpackage

// ### core/srcc_spi_slave.sv
`timescale 1ns/10ps
`include "srcc_defs.svh"
module srcc_spi_slave (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_sdi,
    output logic spi_sdo,
    output logic wr_stb,
    output logic [14:0] addr,
    output logic [7:0] wdata,
    input wire logic [7:0] rdata
);
    // ==========================================
    // pin synchronisers; sclk must stay below ref_clk/8
    logic [2:0] sclk_s;
    logic [2:0] cs_s;
    logic [1:0] sdi_s;
    logic sclk_rise;
    logic sclk_fall;
    srcc_pkg::srcc_spi_state_t st_r;
    logic [4:0] cnt_r;
    logic rnw_r;
    logic load_r;
    logic [14:0] hdr_r;
    logic [7:0] sh_r;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            sclk_s <= 3'h0;
            cs_s <= 3'h7;
            sdi_s <= 2'h0;
        end else begin
            sclk_s <= {sclk_s[1:0], spi_sclk};
            cs_s <= {cs_s[1:0], spi_cs_n};
            sdi_s <= {sdi_s[0], spi_sdi};
        end
    end

    assign sclk_rise = sclk_s[1] & ~sclk_s[2];
    assign sclk_fall = ~sclk_s[1] & sclk_s[2];

    // ==========================================
    // frame state: header, then bytes streamed with ascending address
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            st_r <= srcc_pkg::SPI_IDLE;
            cnt_r <= 5'h00;
            rnw_r <= 1'b0;
            hdr_r <= 15'h0000;
            addr <= 15'h0000;
            wdata <= 8'h00;
            wr_stb <= 1'b0;
            load_r <= 1'b0;
        end else begin
            wr_stb <= 1'b0;
            load_r <= 1'b0;
            if (cs_s[1]) begin
                st_r <= srcc_pkg::SPI_IDLE;
                cnt_r <= 5'h00;
            end else begin
                case (st_r)
                    srcc_pkg::SPI_IDLE: begin
                        st_r <= srcc_pkg::SPI_HDR;
                        cnt_r <= 5'h00;
                    end
                    srcc_pkg::SPI_HDR: begin
                        if (sclk_rise) begin
                            if (cnt_r == 5'h00) begin
                                rnw_r <= sdi_s[1];
                            end else begin
                                hdr_r <= {hdr_r[13:0], sdi_s[1]};
                            end
                            cnt_r <= cnt_r + 5'h01;
                            if (cnt_r == 5'(`SRCC_HDR_BITS - 1)) begin
                                st_r <= srcc_pkg::SPI_DATA;
                                cnt_r <= 5'h00;
                                addr <= {hdr_r[13:0], sdi_s[1]};
                                load_r <= 1'b1;
                            end
                        end
                    end
                    srcc_pkg::SPI_DATA: begin
                        if (sclk_rise) begin
                            cnt_r <= cnt_r + 5'h01;
                            if (cnt_r == 5'(`SRCC_BYTE_BITS - 1)) begin
                                cnt_r <= 5'h00;
                                wdata <= {sh_r[6:0], sdi_s[1]};
                                wr_stb <= ~rnw_r;
                            end
                        end
                        // advance after the write pulse so it uses this byte's address
                        if (wr_stb || (rnw_r && sclk_rise && cnt_r == 5'(`SRCC_BYTE_BITS - 1))) begin
                            addr <= addr + 15'h0001;
                            load_r <= rnw_r;
                        end
                    end
                    default: st_r <= srcc_pkg::SPI_IDLE;
                endcase
            end
        end
    end

    // ==========================================
    // shift register and read data out on falling sclk
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            sh_r <= 8'h00;
            spi_sdo <= 1'b0;
        end else begin
            if (load_r) begin
                sh_r <= rdata;
            end else if (sclk_rise && st_r == srcc_pkg::SPI_DATA) begin
                sh_r <= {sh_r[6:0], sdi_s[1]};
            end
            if (sclk_fall && st_r == srcc_pkg::SPI_DATA && rnw_r) begin
                spi_sdo <= sh_r[7];
            end
        end
    end

    a_wr_single_pulse: assert property (@(posedge ref_clk) disable iff (!nrst)
        wr_stb |=> !wr_stb)
        else $error("write strobe longer than one cycle");
endmodule

// ### verif/tb.sv
`timescale 1ns/10ps
`include "srcc_defs.svh"
module tb;
    // ==========================================
    // stimulus and design
    localparam logic [14:0] a_pri = `SRCC_ADDR_PRIMARY;
    localparam logic [14:0] a_sec = `SRCC_ADDR_SECONDARY;
    localparam logic [14:0] a_ter = `SRCC_ADDR_TERTIARY;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic spi_sclk = 1'b0;
    logic spi_cs_n = 1'b1;
    logic spi_sdi = 1'b0;
    logic sync_pin = 1'b0;
    logic [23:0] pos = 24'h000000;
    logic mark_en = 1'b0;
    logic bypass = 1'b1;
    logic [11:0] smp_in = 12'hABC;
    logic spi_sdo, sync_event, proc_en, recv_en, fine, devclk_dc, sync_dc, invert, marker;
    logic gain, noise;
    logic [11:0] smp_out;
    logic [3:0] tap;
    logic [1:0] del;
    logic [7:0] pri_o, sec_o, ter_o, rd_v;
    int mismatches = 0;
    int tests_run = 0;
    int n, n0, n1, n2;
    assign pri_o = {1'b0, proc_en, recv_en, fine, tap};
    assign sec_o = {4'h0, marker, devclk_dc, sync_dc, invert};
    assign ter_o = {3'h0, gain, 1'b0, noise, del};
    always #12.5 ref_clk = ~ref_clk;
    srcc_top dut_u (.ref_clk(ref_clk), .nrst(nrst), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
        .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .sync_pin(sync_pin), .sync_capture_position(pos),
        .sample_marker_enable(mark_en), .decim_bypass(bypass), .sample_in(smp_in),
        .sample_out(smp_out), .sync_event(sync_event), .sync_receiver_enable(recv_en),
        .sync_processor_enable(proc_en), .sync_window_fine_steps(fine),
        .sync_delay_tap_select(tap), .device_clock_dc_mode(devclk_dc),
        .sync_input_dc_mode(sync_dc), .sync_polarity_invert(invert),
        .sync_as_sample_marker(marker), .clock_feedback_gain(gain),
        .analog_supply_noise_suppress(noise), .sampling_clock_delay(del));
    // ==========================================
    // compare and bus tasks
    task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
        tests_run++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_cnt(input string nm, input int e, input int g);
        tests_run++;
        if (g != e) begin
            mismatches++;
            $display("[FAIL] %s expected %0d seen %0d", nm, e, g);
        end
    endtask
    // ten ref_clk per serial bit keeps the serial clock well inside the sync limit
    task automatic spi(input logic rw, input logic [14:0] a, input logic [7:0] wd);
        logic [23:0] bits;
        bits = {rw, a, wd};
        rd_v = 8'h00;
        @(negedge ref_clk);
        spi_cs_n = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            spi_sdi = bits[i];
            repeat (5) @(negedge ref_clk);
            if (i < 8) rd_v[i] = spi_sdo;
            spi_sclk = 1'b1;
            repeat (5) @(negedge ref_clk);
            spi_sclk = 1'b0;
        end
        repeat (8) @(negedge ref_clk);
        spi_cs_n = 1'b1;
        spi_sdi = 1'b0;
        repeat (4) @(negedge ref_clk);
    endtask
    task automatic rd(input string nm, input logic [14:0] a, input logic [7:0] e);
        spi(1'b1, a, 8'h00);
        chk(nm, 24'(e), 24'(rd_v));
    endtask
    // cycles from a pin change to the event pulse, 80 when none comes
    task automatic lat(input logic v, output int c);
        c = 0;
        @(negedge ref_clk);
        sync_pin = v;
        while (sync_event !== 1'b1 && c < 80) begin
            @(negedge ref_clk);
            c++;
        end
    endtask
    // ==========================================
    // scenarios
    task automatic test_reset();
        chk("primary outputs", 24'h0, 24'(pri_o));
        chk("secondary outputs", 24'h0, 24'(sec_o));
        chk("tertiary outputs", 24'h11, 24'(ter_o));
        rd("primary reset", a_pri, 8'h00);
        rd("secondary reset", a_sec, 8'h00);
        rd("tertiary reset", a_ter, 8'h11);
        rd("unmapped read", 15'h007F, 8'h00);
        $display("test_reset done");
    endtask
    task automatic test_regs();
        spi(1'b0, a_pri, 8'h20);
        spi(1'b0, a_pri, 8'h6A);
        chk("primary fields", 24'h6A, 24'(pri_o));
        rd("primary readback", a_pri, 8'h6A);
        spi(1'b0, a_pri, 8'h35);
        chk("fine and tap", 24'h35, 24'(pri_o));
        for (int i = 0; i < 4; i++) begin
            spi(1'b0, a_sec, 8'h01 << i);
            chk("secondary bit", 24'h1 << i, 24'(sec_o));
            rd("secondary readback", a_sec, 8'h01 << i);
        end
        spi(1'b0, a_sec, 8'h00);
        spi(1'b0, a_ter, 8'h05);
        chk("tertiary fields", 24'h05, 24'(ter_o));
        spi(1'b0, a_ter, 8'h12);
        chk("tertiary fields", 24'h12, 24'(ter_o));
        rd("tertiary readback", a_ter, 8'h12);
        $display("test_regs done");
    endtask
    task automatic test_position();
        pos = 24'hC3A55A;
        spi(1'b0, `SRCC_ADDR_POS0, 8'hFF);
        rd("position low", `SRCC_ADDR_POS0, 8'h5A);
        rd("position mid", `SRCC_ADDR_POS1, 8'hA5);
        rd("position high", `SRCC_ADDR_POS2, 8'hC3);
        $display("test_position done");
    endtask
    task automatic test_sync();
        spi(1'b0, a_pri, 8'h20);
        lat(1'b1, n);
        chk_cnt("event with processor off", 80, n);
        lat(1'b0, n);
        spi(1'b0, a_pri, 8'h60);
        lat(1'b1, n0);
        chk_cnt("event with processor on", 5, n0);
        lat(1'b0, n);
        chk_cnt("event on falling pin", 80, n);
        spi(1'b0, a_pri, 8'h63);
        lat(1'b1, n1);
        chk_cnt("coarse tap delay", 6, n1 - n0);
        lat(1'b0, n);
        spi(1'b0, a_pri, 8'h73);
        lat(1'b1, n2);
        chk_cnt("fine tap delay", 3, n2 - n0);
        lat(1'b0, n);
        // the write itself turns the low pin into a rising edge, so settle first
        spi(1'b0, a_sec, 8'h01);
        lat(1'b1, n);
        chk_cnt("inverted rising pin", 80, n);
        lat(1'b0, n);
        chk_cnt("inverted falling pin", 8, n);
        spi(1'b0, a_sec, 8'h00);
        $display("test_sync done");
    endtask
    task automatic test_marker();
        spi(1'b0, a_pri, 8'h20);
        spi(1'b0, a_sec, 8'h08);
        mark_en = 1'b1;
        sync_pin = 1'b1;
        repeat (10) @(negedge ref_clk);
        chk("marker high", 24'hABD, 24'(smp_out));
        sync_pin = 1'b0;
        smp_in = 12'h541;
        repeat (10) @(negedge ref_clk);
        chk("marker low", 24'h540, 24'(smp_out));
        bypass = 1'b0;
        repeat (10) @(negedge ref_clk);
        chk("decimating", 24'h541, 24'(smp_out));
        bypass = 1'b1;
        mark_en = 1'b0;
        repeat (10) @(negedge ref_clk);
        chk("marker enable off", 24'h541, 24'(smp_out));
        $display("test_marker done");
    endtask
    // reset in mid-run must bring every register back to its reset value
    task automatic test_reset_mid();
        @(negedge ref_clk);
        nrst = 1'b0;
        repeat (5) @(negedge ref_clk);
        nrst = 1'b1;
        repeat (4) @(negedge ref_clk);
        chk("primary after reset", 24'h0, 24'(pri_o));
        chk("secondary after reset", 24'h0, 24'(sec_o));
        chk("tertiary after reset", 24'h11, 24'(ter_o));
        rd("tertiary read after reset", a_ter, 8'h11);
        $display("test_reset_mid done");
    endtask
    // ==========================================
    // verdict
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge ref_clk);
        mismatches++;
        $display("watchdog expired");
        end_of_test();
    end
    initial begin
        repeat (5) @(negedge ref_clk);
        nrst = 1'b1;
        repeat (4) @(negedge ref_clk);
        test_reset();
        test_regs();
        test_position();
        test_sync();
        test_marker();
        test_reset_mid();
        end_of_test();
    end
endmodule
